// [logic/acv_pkg.sv]
package acv_pkg;
	localparam int ACV_DATA_W = 12;
	localparam int ACV_PIPE_DELAY = 7;
	localparam int ACV_FIFO_DEPTH = 8;
	localparam int ACV_CLK_PERIOD_NS = 50;
	// relock allowance after a rate change, in sample clocks
	localparam int ACV_RELOCK_CYCLES = 100;
	// reference recovery after a full-discharge standby
	localparam int ACV_WAKE_MS = 7;
	localparam int ACV_WAKE_CYCLES = ACV_WAKE_MS * 1000000 / ACV_CLK_PERIOD_NS;
	// standby time for full discharge of the reference capacitors
	localparam int ACV_DISCHARGE_MS = 1000;
	localparam int ACV_DISCHARGE_CYCLES = ACV_DISCHARGE_MS * 1000000 / ACV_CLK_PERIOD_NS;
	localparam int ACV_CNT_W = 25;
	localparam logic [ACV_DATA_W-1:0] ACV_DATA_RST = 12'h000;
	localparam logic [ACV_DATA_W-1:0] ACV_SIGN_FLIP = 12'h800;

	// multilevel mode pin, as seen by its comparators
	typedef enum logic [1:0] {
		ACV_MODE_GROUND,
		ACV_MODE_THIRD,
		ACV_MODE_TWO_THIRDS,
		ACV_MODE_SUPPLY
	} acv_mode_level_t;

	// reference-select pin, as seen by its comparator
	typedef enum logic [1:0] {
		ACV_SENSE_LOW,
		ACV_SENSE_DIVIDER,
		ACV_SENSE_AT_REF,
		ACV_SENSE_SUPPLY
	} acv_sense_level_t;

	typedef enum logic [1:0] {
		ACV_REF_1V0,
		ACV_REF_PROGRAMMABLE,
		ACV_REF_0V5,
		ACV_REF_EXTERNAL
	} acv_ref_mode_t;
endpackage : acv_pkg

// [logic/acv_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface acv_link_if;
	import acv_pkg::*;
	logic sample_clk;
	logic standby_request;
	logic [ACV_DATA_W-1:0] data_out;
	logic [ACV_DATA_W-1:0] data_oe;
	acv_mode_level_t mode_level;
	acv_sense_level_t sense_level;

	modport converter (
		input sample_clk,
		input standby_request,
		input mode_level,
		input sense_level,
		output data_out,
		output data_oe
	);

	modport capture (
		output sample_clk,
		output standby_request,
		output mode_level,
		output sense_level,
		input data_out,
		input data_oe
	);
endinterface : acv_link_if
`default_nettype wire

// [logic/acv_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module acv_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : acv_fifo
`default_nettype wire

// [logic/acv_converter.sv]
// Overview of operation
// - result appears seven clocks after sampling
// - output word is twelve bits wide
// - standby request high enters low-power standby
// - data drivers float during standby
// - standby request low resumes conversion
// - host waits reference recovery after standby
// - restorer gives nominal half-duty internal clock
// - host allows relock cycles after rate change with restorer on
// - keep sample clock at least 1 MSPS
// - retime derived sample clocks with clean clock
// - output coding offset binary or twos complement
// - reference pin picks one of four references
// - mode pin decodes format and restorer state
// - new sample taken on rising clock edge
`timescale 1ns/1ps
`default_nettype none
module acv_converter
	import acv_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// link to the capture end
	acv_link_if.converter link,
	// analog front end stand-in
	input wire logic [ACV_DATA_W-1:0] sample_i,
	// status
	output logic standby_o,
	output logic restorer_on_o,
	output logic twos_complement_o,
	output acv_ref_mode_t ref_mode_o,
	output logic [ACV_DATA_W-1:0] data_o
);
	logic [ACV_DATA_W-1:0] pipe [ACV_PIPE_DELAY];
	logic [ACV_DATA_W-1:0] next_word;
	logic twos;
	logic restorer;
	acv_ref_mode_t ref_mode;

	// mode pin: format and restorer state
	always_comb begin
		unique case (link.mode_level)
			ACV_MODE_SUPPLY: begin
				twos = 1'b1;
				restorer = 1'b0;
			end
			ACV_MODE_TWO_THIRDS: begin
				twos = 1'b1;
				restorer = 1'b1;
			end
			ACV_MODE_THIRD: begin
				twos = 1'b0;
				restorer = 1'b1;
			end
			ACV_MODE_GROUND: begin
				twos = 1'b0;
				restorer = 1'b0;
			end
		endcase
	end

	always_comb begin
		unique case (link.sense_level)
			ACV_SENSE_LOW: ref_mode = ACV_REF_1V0;
			ACV_SENSE_AT_REF: ref_mode = ACV_REF_0V5;
			ACV_SENSE_DIVIDER: ref_mode = ACV_REF_PROGRAMMABLE;
			ACV_SENSE_SUPPLY: ref_mode = ACV_REF_EXTERNAL;
		endcase
	end

	// msb flip turns offset binary into twos complement
	assign next_word = twos ? (pipe[ACV_PIPE_DELAY-1] ^ ACV_SIGN_FLIP) : pipe[ACV_PIPE_DELAY-1];

	// sample enters on the rising edge; stages shift every clock
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pipe[0] <= ACV_DATA_RST;
		end else begin
			pipe[0] <= sample_i;
		end
	end

	for (genvar s = 1; s < ACV_PIPE_DELAY - 1; s++) begin : g_stage
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				pipe[s] <= ACV_DATA_RST;
			end else begin
				pipe[s] <= pipe[s-1];
			end
		end
	end

	// last stage plus output latch gives eight edges total
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pipe[ACV_PIPE_DELAY-1] <= ACV_DATA_RST;
			data_o <= ACV_DATA_RST;
		end else begin
			pipe[ACV_PIPE_DELAY-1] <= pipe[ACV_PIPE_DELAY-2];
			data_o <= next_word;
		end
	end

	// standby shuts reference and bias; pipeline keeps clocking
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			standby_o <= 1'b0;
		end else begin
			standby_o <= link.standby_request;
		end
	end

	// the restorer is analog; only its enable state is visible here
	assign restorer_on_o = restorer;
	assign twos_complement_o = twos;
	assign ref_mode_o = ref_mode;
	assign link.data_out = data_o;
	assign link.data_oe = standby_o ? '0 : '1;
endmodule : acv_converter
`default_nettype wire

// [logic/acv_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module acv_capture
	import acv_pkg::*;
#(
	parameter int WAKE_CYCLES = ACV_WAKE_CYCLES,
	parameter int DISCHARGE_CYCLES = ACV_DISCHARGE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// link to the converter
	acv_link_if.capture link,
	// user control
	input wire logic standby_i,
	input wire logic rate_change_i,
	input wire logic restorer_on_i,
	input wire logic twos_complement_i,
	input wire acv_ref_mode_t ref_mode_i,
	// sample stream out
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [ACV_DATA_W-1:0] out_data_o,
	output logic overflow_o
);
	logic [ACV_DATA_W-1:0] word;
	logic word_ok;
	logic [3:0] discard;
	logic [6:0] relock;
	logic [ACV_CNT_W-1:0] wake;
	logic [ACV_CNT_W-1:0] asleep;
	logic in_ready;

	// derived clock is a pass-through of the clean clock
	assign link.sample_clk = clk_i;
	assign link.standby_request = standby_i;
	assign link.mode_level = twos_complement_i ?
		(restorer_on_i ? ACV_MODE_TWO_THIRDS : ACV_MODE_SUPPLY) :
		(restorer_on_i ? ACV_MODE_THIRD : ACV_MODE_GROUND);
	assign link.sense_level = (ref_mode_i == ACV_REF_1V0) ? ACV_SENSE_LOW :
		(ref_mode_i == ACV_REF_0V5) ? ACV_SENSE_AT_REF :
		(ref_mode_i == ACV_REF_PROGRAMMABLE) ? ACV_SENSE_DIVIDER : ACV_SENSE_SUPPLY;

	// register the word on the edge after it settled
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			word <= ACV_DATA_RST;
			word_ok <= 1'b0;
		end else begin
			word <= link.data_out;
			word_ok <= (&link.data_oe) && !standby_i;
		end
	end

	// standby time scales the wake wait, capped at full discharge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			asleep <= '0;
			wake <= '0;
		end else if (standby_i) begin
			if (asleep < ACV_CNT_W'(DISCHARGE_CYCLES)) begin
				asleep <= asleep + 1'b1;
			end
			wake <= '0;
		end else if (asleep != '0) begin
			// proportional: wake = asleep * wake / discharge, computed by one 64-bit multiply and divide
			wake <= ACV_CNT_W'(64'(asleep) * 64'(WAKE_CYCLES) / 64'(DISCHARGE_CYCLES));
			asleep <= '0;
		end else if (wake != '0) begin
			wake <= wake - 1'b1;
		end
	end

	// relock wait; counted on every edge, restarted by a rate change while the restorer is on
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			relock <= '0;
		end else if (rate_change_i && restorer_on_i) begin
			relock <= 7'(ACV_RELOCK_CYCLES);
		end else if (relock != '0) begin
			relock <= relock - 1'b1;
		end
	end

	// first seven words after start or wake are stale; the capture register
	// adds one more word, taken while the converter was still held
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || standby_i) begin
			discard <= 4'(ACV_PIPE_DELAY + 1);
		end else if (word_ok && discard != '0) begin
			discard <= discard - 1'b1;
		end
	end

	// stream is assumed to run at or above the minimum rate
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			overflow_o <= 1'b0;
		end else if (word_ok && discard == '0 && wake == '0 && relock == '0 && !in_ready) begin
			overflow_o <= 1'b1;
		end
	end

	acv_fifo #(
		.WIDTH(ACV_DATA_W),
		.DEPTH(ACV_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(word_ok && discard == '0 && wake == '0 && relock == '0),
		.in_ready_o(in_ready),
		.in_data_i(word),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(out_data_o)
	);
endmodule : acv_capture
`default_nettype wire

// [dv/acv_link_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module acv_link_monitor
	import acv_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// link signals
	input wire logic sample_clk,
	input wire logic standby_request,
	input wire logic [ACV_DATA_W-1:0] data_out,
	input wire logic [ACV_DATA_W-1:0] data_oe,
	input wire acv_mode_level_t mode_level,
	input wire acv_sense_level_t sense_level
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// drivers switch as a group, never a partial bus
	AST_OE_WHOLE: assert property (data_oe == '0 || data_oe == '1)
		else $error("output enables split");
	AST_OE_KEPT_AT_REQ: assert property ($rose(standby_request) |-> data_oe == '1)
		else $error("drivers dropped before standby edge");
	AST_OE_FLOAT_NEXT: assert property ($rose(standby_request) |=> data_oe == '0)
		else $error("drivers on after standby entry");
	AST_OE_FLOAT_HOLD: assert property (standby_request [*2] |-> data_oe == '0)
		else $error("drivers on during standby");
	AST_OE_STILL_OFF: assert property
		($fell(standby_request) && $past(rst_n_i) |-> data_oe == '0)
		else $error("drivers back too early");
	AST_OE_BACK_NEXT: assert property ($fell(standby_request) |=> data_oe == '1)
		else $error("drivers not back after wake");
	AST_OE_AWAKE: assert property (!standby_request [*2] |-> data_oe == '1)
		else $error("drivers off while awake");
endmodule : acv_link_monitor
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import acv_pkg::*;
	logic clk_i, rst_n_i, standby_i, rate_change_i, restorer_on_i, twos_complement_i;
	logic out_ready_i, out_valid_o, overflow_o, standby_o, restorer_on_o, twos_complement_o;
	logic [ACV_DATA_W-1:0] sample_i, out_data_o, data_o;
	acv_ref_mode_t ref_mode_i, ref_mode_o;
	logic [ACV_DATA_W-1:0] q[$];
	int err_total, checks, seed, nout, base;
	bit track;
	acv_link_if link();
	acv_converter acv_converter_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
		.sample_i(sample_i), .standby_o(standby_o), .restorer_on_o(restorer_on_o),
		.twos_complement_o(twos_complement_o), .ref_mode_o(ref_mode_o), .data_o(data_o));
	// short wake counts keep the standby scenario brief
	acv_capture #(.WAKE_CYCLES(20), .DISCHARGE_CYCLES(100)) acv_capture_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .link(link), .standby_i(standby_i), .rate_change_i(rate_change_i),
		.restorer_on_i(restorer_on_i), .twos_complement_i(twos_complement_i),
		.ref_mode_i(ref_mode_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
		.out_data_o(out_data_o), .overflow_o(overflow_o));
	acv_link_monitor acv_link_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sample_clk(link.sample_clk), .standby_request(link.standby_request),
		.data_out(link.data_out), .data_oe(link.data_oe), .mode_level(link.mode_level),
		.sense_level(link.sense_level));
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	task automatic check(input logic [ACV_DATA_W-1:0] got, input logic [ACV_DATA_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask : check
	function automatic logic [ACV_DATA_W-1:0] code(input logic [ACV_DATA_W-1:0] s);
		return twos_complement_i ? s ^ ACV_SIGN_FLIP : s;
	endfunction : code
	// each sample is noted while track is set, since each one is taken at the next rising edge
	task automatic cyc(input int n);
		repeat (n) begin
			@(negedge clk_i);
			sample_i = $random(seed);
			if (track) q.push_back(code(sample_i));
		end
	endtask : cyc
	task automatic do_reset();
		rst_n_i = 1'h0;
		track = 0;
		q.delete();
		cyc(6);
		rst_n_i = 1'h1;
	endtask : do_reset
	task automatic flush();
		track = 0;
		for (int i = 0; i < 40 && q.size() > 0; i++) cyc(1);
		if (q.size() > 0) begin
			err_total++;
			results();
		end
	endtask : flush
	task automatic wait_out(input int lim);
		base = nout;
		for (int i = 0; i < lim && nout == base; i++) cyc(1);
		if (nout == base) begin
			err_total++;
			results();
		end
	endtask : wait_out
	always @(posedge clk_i) begin
		if (rst_n_i === 1'h1 && out_valid_o === 1'h1 && out_ready_i) begin
			if (q.size() > 0) check(out_data_o, q.pop_front());
			else if (track) begin
				$display("unexpected at %0t: got %h expected %h", $time, out_data_o, 12'h000);
				err_total++;
			end else nout++;
		end
	end
	initial begin
		seed = 32'h555d;
		sample_i = 12'h000;
		{standby_i, rate_change_i, restorer_on_i, twos_complement_i, rst_n_i} = 5'h00;
		out_ready_i = 1'h1;
		ref_mode_i = ACV_REF_1V0;
		{err_total, checks, nout, track} = 0;
		for (int m = 0; m < 4; m++) begin
			restorer_on_i = m[0];
			twos_complement_i = m[1];
			ref_mode_i = acv_ref_mode_t'(m);
			do_reset();
			check(restorer_on_o, m[0]);
			check(twos_complement_o, m[1]);
			check(ref_mode_o, ref_mode_i);
			track = 1;
			q.push_back(code(sample_i));
			cyc(40);
			flush();
			$display("stream mode %0d done", m);
		end
		rate_change_i = 1'h1;
		cyc(1);
		rate_change_i = 1'h0;
		cyc(20);
		base = nout;
		cyc(75);
		check(12'(nout - base), 12'h000);
		wait_out(100);
		$display("relock done");
		standby_i = 1'h1;
		cyc(2);
		check(link.data_oe, 12'h000);
		check(standby_o, 1'h1);
		cyc(10);
		base = nout;
		cyc(20);
		check(12'(nout - base), 12'h000);
		standby_i = 1'h0;
		cyc(2);
		check(link.data_oe, 12'hfff);
		wait_out(200);
		$display("standby done");
		out_ready_i = 1'h0;
		cyc(30);
		check(overflow_o, 1'h1);
		check(out_valid_o, 1'h1);
		// standby stops the inflow so the buffer can run dry
		standby_i = 1'h1;
		out_ready_i = 1'h1;
		for (int i = 0; i < 40 && out_valid_o === 1'h1; i++) cyc(1);
		check(out_valid_o, 1'h0);
		// leave standby first so the reset does not cut a standby period
		standby_i = 1'h0;
		do_reset();
		check(overflow_o, 1'h0);
		$display("buffer done");
		results();
	end
endmodule : tb_top
`default_nettype wire
